// ### csbu_top.sv
// compare, skip and branch execution unit with apb status port
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "csbu_params.svh"
module csbu_top #(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [`CSBU_ADDR_W-1:0] paddr_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [31:0]             pwdata_i,
  output logic                         pready_o,
  output logic      [31:0]             prdata_o,
  output logic                         pslverr_o,
  input  wire logic                    op_valid_i,
  input  wire csbu_pkg::csbu_op_t      op_i,
  input  wire logic [7:0]              rd_val_i,
  input  wire logic [7:0]              rr_val_i,
  input  wire logic [7:0]              io_val_i,
  input  wire logic [2:0]              bit_sel_i,
  input  wire logic [OFS_W-1:0]        offset_i,
  input  wire logic [PC_W-1:0]         pc_i,
  input  wire logic                    next_two_word_i,
  input  wire logic [7:0]              status_register_i,
  output logic                         op_ready_o,
  output logic                         done_o,
  output logic                         pc_load_o,
  output logic      [PC_W-1:0]         pc_target_o,
  output logic                         status_register_we_o,
  output logic      [7:0]              status_register_o,
  output logic      [1:0]              cycles_o
);
  import csbu_pkg::*;

  typedef struct packed {
    logic            done;
    logic            pc_load;
    logic [PC_W-1:0] pc_target;
    logic            status_register_we;
    logic [7:0]      status_register;
    logic [1:0]      cycles;
    logic [1:0]      wait_cnt;
    logic            taken;
    logic            flags_upd;
    logic            enable;
    logic [15:0]     taken_cnt;
    logic [15:0]     exec_cnt;
    logic [31:0]     prdata;
    logic            slverr;
  } csbu_state_t;

  csbu_state_t s_q;
  csbu_state_t s_d;

  csbu_exec_if ex ();

  logic [PC_W-1:0] ofs_ext;
  logic [7:0]      status_register_eff;
  logic            accept;
  logic            wr_en;
  logic            rd_setup;
  logic [1:0]      cyc;
  logic [PC_W-1:0] tgt;

  // address decode shared by read and write paths
  function automatic logic reg_hit(input logic [`CSBU_ADDR_W-1:0] a);
    reg_hit = (a == `CSBU_OFS_CTRL) || (a == `CSBU_OFS_STAT) ||
              (a == `CSBU_OFS_CNT)  || (a == `CSBU_OFS_STATUS_REGISTER);
  endfunction

  csbu_flag_unit u_flag (
    .ex (ex.flag)
  );

  csbu_cond_unit u_cond (
    .ex (ex.cond)
  );

  // forward flags written last cycle so compare then branch back to
  // back sees fresh flags before the core register catches up
  assign status_register_eff   = (s_q.done && s_q.status_register_we) ? s_q.status_register : status_register_i;

  assign ex.op      = op_i;
  assign ex.rd_val  = rd_val_i;
  assign ex.rr_val  = rr_val_i;
  assign ex.io_val  = io_val_i;
  assign ex.bit_sel = bit_sel_i;
  assign ex.status_register    = status_register_eff;

  assign ofs_ext = {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};

  // stall while a multi-cycle outcome drains
  assign op_ready_o = s_q.enable && (s_q.wait_cnt == 2'h0);
  assign accept     = op_valid_i && op_ready_o;
  assign wr_en      = psel_i && penable_i && pwrite_i &&
                      reg_hit(paddr_i);
  assign rd_setup   = psel_i && !penable_i;

  // outcome length and target of the offered instruction
  always_comb begin
    cyc = `CSBU_CYC_ONE;
    tgt = pc_i;
    if (ex.is_skip) begin
      if (next_two_word_i) begin
        tgt = pc_i + PC_W'(`CSBU_PC_SKIP_2W);
      end else begin
        tgt = pc_i + PC_W'(`CSBU_PC_SKIP_1W);
      end
      if (ex.hit) begin
        cyc = next_two_word_i ? `CSBU_CYC_THREE : `CSBU_CYC_TWO;
      end
    end else if (ex.is_branch) begin
      tgt = pc_i + ofs_ext + PC_W'(`CSBU_PC_BR_BIAS);
      if (ex.hit) begin
        cyc = `CSBU_CYC_TWO;
      end
    end
  end

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (s_q.wait_cnt != 2'h0) begin
      s_d.wait_cnt = s_q.wait_cnt - 2'h1;
    end
    if (accept) begin
      s_d.done      = 1'b1;
      s_d.cycles    = cyc;
      s_d.wait_cnt  = cyc - 2'h1;
      s_d.taken     = (ex.is_skip || ex.is_branch) && ex.hit;
      s_d.pc_load   = (ex.is_skip || ex.is_branch) && ex.hit;
      s_d.pc_target = tgt;
      // skips and branches never write flags
      s_d.status_register_we   = ex.flags_we;
      s_d.flags_upd = ex.flags_we;
      s_d.status_register      = ex.flags_new;
    end
    // counters: a clear that meets a count keeps the count
    if (wr_en && paddr_i == `CSBU_OFS_CTRL &&
        pwdata_i[`CSBU_CTRL_CLR_BIT]) begin
      s_d.taken_cnt = 16'h0000;
      s_d.exec_cnt  = 16'h0000;
    end
    if (accept) begin
      s_d.exec_cnt = s_d.exec_cnt + 16'h0001;
      if (s_d.taken) begin
        s_d.taken_cnt = s_d.taken_cnt + 16'h0001;
      end
    end
    if (wr_en && paddr_i == `CSBU_OFS_CTRL) begin
      s_d.enable = pwdata_i[`CSBU_CTRL_EN_BIT];
    end
    // read data captured in setup so it comes from a flop
    if (rd_setup) begin
      s_d.slverr = !reg_hit(paddr_i);
      s_d.prdata = 32'h0000_0000;
      unique case (paddr_i)
        `CSBU_OFS_CTRL: s_d.prdata[`CSBU_CTRL_EN_BIT] = s_q.enable;
        `CSBU_OFS_STAT: begin
          s_d.prdata[`CSBU_STAT_CYC_LSB +: 2] = s_q.cycles;
          s_d.prdata[`CSBU_STAT_TAKEN]        = s_q.taken;
          s_d.prdata[`CSBU_STAT_BUSY]         = (s_q.wait_cnt != 2'h0);
          s_d.prdata[`CSBU_STAT_FLAGS]        = s_q.flags_upd;
        end
        `CSBU_OFS_CNT:  s_d.prdata = {s_q.exec_cnt, s_q.taken_cnt};
        `CSBU_OFS_STATUS_REGISTER: s_d.prdata[7:0] = status_register_eff;
        default:        s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q        <= '0;
      s_q.enable <= `CSBU_CTRL_EN_RST;
      s_q.cycles <= `CSBU_CYC_ONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_o    = 1'b1;
  assign prdata_o    = s_q.prdata;
  assign pslverr_o   = psel_i && penable_i && s_q.slverr;
  assign done_o      = s_q.done;
  assign pc_load_o   = s_q.done && s_q.pc_load;
  assign pc_target_o = s_q.pc_target;
  assign status_register_we_o   = s_q.done && s_q.status_register_we;
  assign status_register_o      = s_q.status_register;
  assign cycles_o    = s_q.cycles;

endmodule

// ### csbu_params.svh
// constants for the compare, skip and branch unit
`ifndef CSBU_PARAMS_SVH
`define CSBU_PARAMS_SVH

// status register bit positions
`define CSBU_FLAG_C        3'h0
`define CSBU_FLAG_Z        3'h1
`define CSBU_FLAG_N        3'h2
`define CSBU_FLAG_V        3'h3
`define CSBU_FLAG_S        3'h4
`define CSBU_FLAG_H        3'h5
`define CSBU_FLAG_T        3'h6
`define CSBU_FLAG_I        3'h7

// apb register byte offsets
`define CSBU_ADDR_W        8
`define CSBU_OFS_CTRL      8'h00
`define CSBU_OFS_STAT      8'h04
`define CSBU_OFS_CNT       8'h08
`define CSBU_OFS_STATUS_REGISTER      8'h0c

// control register fields and reset
`define CSBU_CTRL_EN_BIT   0
`define CSBU_CTRL_CLR_BIT  1
`define CSBU_CTRL_EN_RST   1'h1

// status register fields
`define CSBU_STAT_CYC_LSB  0
`define CSBU_STAT_TAKEN    2
`define CSBU_STAT_BUSY     3
`define CSBU_STAT_FLAGS    4

// cycle counts and program counter steps
`define CSBU_CYC_ONE       2'h1
`define CSBU_CYC_TWO       2'h2
`define CSBU_CYC_THREE     2'h3
`define CSBU_PC_SKIP_1W    32'h2
`define CSBU_PC_SKIP_2W    32'h3
`define CSBU_PC_BR_BIAS    32'h1

`endif

// ### csbu_pkg.sv
// types shared by the compare, skip and branch unit
package csbu_pkg;

  typedef enum logic [4:0] {
    op_compare_skip_equal,
    op_compare_regs,
    op_compare_regs_with_carry,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_status_bit_set,
    op_branch_status_bit_clear,
    op_branch_equal,
    op_branch_not_equal,
    op_branch_carry_set,
    op_branch_carry_clear,
    op_branch_same_or_higher,
    op_branch_lower,
    op_branch_minus,
    op_branch_plus,
    op_branch_signed_ge,
    op_branch_signed_lt,
    op_branch_half_carry_set,
    op_branch_half_carry_clear,
    op_branch_transfer_bit_set,
    op_branch_transfer_bit_clear,
    op_branch_overflow_set,
    op_branch_overflow_clear,
    op_branch_irq_enabled,
    op_branch_irq_disabled
  } csbu_op_t;

endpackage

// ### csbu_exec_if.sv
// operand and result bundle between the unit and its helpers
`timescale 1ns/100ps
interface csbu_exec_if;
  import csbu_pkg::*;

  csbu_op_t    op;
  logic [7:0]  rd_val;
  logic [7:0]  rr_val;
  logic [7:0]  io_val;
  logic [2:0]  bit_sel;
  logic [7:0]  status_register;
  logic        flags_we;
  logic [7:0]  flags_new;
  logic        hit;
  logic        is_skip;
  logic        is_branch;

  modport core (output op, rd_val, rr_val, io_val, bit_sel, status_register,
                input  flags_we, flags_new, hit, is_skip, is_branch);
  modport flag (input  op, rd_val, rr_val, status_register,
                output flags_we, flags_new);
  modport cond (input  op, rd_val, rr_val, io_val, bit_sel, status_register,
                output hit, is_skip, is_branch);
endinterface

// ### csbu_flag_unit.sv
// subtract-and-flag logic for the compare operations
`timescale 1ns/100ps
`include "csbu_params.svh"
module csbu_flag_unit (
  csbu_exec_if.flag ex
);
  import csbu_pkg::*;

  logic [7:0] res;
  logic       cin;
  logic       cmp;
  logic       rd7;
  logic       rr7;
  logic       r7;

  always_comb begin
    cin = 1'b0;
    cmp = 1'b0;
    case (ex.op)
      op_compare_regs:            cmp = 1'b1;
      op_compare_immediate:       cmp = 1'b1;
      op_compare_regs_with_carry: begin
        cmp = 1'b1;
        cin = ex.status_register[`CSBU_FLAG_C];
      end
      default:                    cmp = 1'b0;
    endcase
    // result is never stored, only flags
    res = ex.rd_val - ex.rr_val - {7'h00, cin};
    rd7 = ex.rd_val[7];
    rr7 = ex.rr_val[7];
    r7  = res[7];
    ex.flags_new = ex.status_register;
    ex.flags_new[`CSBU_FLAG_Z] = (res == 8'h00);
    ex.flags_new[`CSBU_FLAG_N] = r7;
    ex.flags_new[`CSBU_FLAG_V] = (rd7 & ~rr7 & ~r7) | (~rd7 & rr7 & r7);
    ex.flags_new[`CSBU_FLAG_C] = (~rd7 & rr7) | (rr7 & r7) | (r7 & ~rd7);
    ex.flags_new[`CSBU_FLAG_H] = (~ex.rd_val[3] & ex.rr_val[3])
                               | (ex.rr_val[3] & res[3])
                               | (res[3] & ~ex.rd_val[3]);
    ex.flags_we = cmp;
  end
endmodule

// ### csbu_cond_unit.sv
// skip and branch condition evaluation
`timescale 1ns/100ps
`include "csbu_params.svh"
module csbu_cond_unit (
  csbu_exec_if.cond ex
);
  import csbu_pkg::*;

  logic [7:0] s;

  always_comb begin
    s            = ex.status_register;
    ex.hit       = 1'b0;
    ex.is_skip   = 1'b0;
    ex.is_branch = 1'b1;
    case (ex.op)
      op_compare_skip_equal: begin
        ex.is_skip = 1'b1;
        ex.hit     = (ex.rd_val == ex.rr_val);
      end
      op_skip_reg_bit_clear: begin
        ex.is_skip = 1'b1;
        ex.hit     = ~ex.rr_val[ex.bit_sel];
      end
      op_skip_reg_bit_set: begin
        ex.is_skip = 1'b1;
        ex.hit     = ex.rr_val[ex.bit_sel];
      end
      op_skip_io_bit_clear: begin
        ex.is_skip = 1'b1;
        ex.hit     = ~ex.io_val[ex.bit_sel];
      end
      op_skip_io_bit_set: begin
        ex.is_skip = 1'b1;
        ex.hit     = ex.io_val[ex.bit_sel];
      end
      op_branch_status_bit_set:     ex.hit = s[ex.bit_sel];
      op_branch_status_bit_clear:   ex.hit = ~s[ex.bit_sel];
      op_branch_equal:              ex.hit = s[`CSBU_FLAG_Z];
      op_branch_not_equal:          ex.hit = ~s[`CSBU_FLAG_Z];
      op_branch_carry_set:          ex.hit = s[`CSBU_FLAG_C];
      op_branch_lower:              ex.hit = s[`CSBU_FLAG_C];
      op_branch_carry_clear:        ex.hit = ~s[`CSBU_FLAG_C];
      op_branch_same_or_higher:     ex.hit = ~s[`CSBU_FLAG_C];
      op_branch_minus:              ex.hit = s[`CSBU_FLAG_N];
      op_branch_plus:               ex.hit = ~s[`CSBU_FLAG_N];
      op_branch_signed_ge:
        ex.hit = ~(s[`CSBU_FLAG_N] ^ s[`CSBU_FLAG_V]);
      op_branch_signed_lt:
        ex.hit = s[`CSBU_FLAG_N] ^ s[`CSBU_FLAG_V];
      op_branch_half_carry_set:     ex.hit = s[`CSBU_FLAG_H];
      op_branch_half_carry_clear:   ex.hit = ~s[`CSBU_FLAG_H];
      op_branch_transfer_bit_set:   ex.hit = s[`CSBU_FLAG_T];
      op_branch_transfer_bit_clear: ex.hit = ~s[`CSBU_FLAG_T];
      op_branch_overflow_set:       ex.hit = s[`CSBU_FLAG_V];
      op_branch_overflow_clear:     ex.hit = ~s[`CSBU_FLAG_V];
      op_branch_irq_enabled:        ex.hit = s[`CSBU_FLAG_I];
      op_branch_irq_disabled:       ex.hit = ~s[`CSBU_FLAG_I];
      default:                      ex.is_branch = 1'b0;
    endcase
  end
endmodule

// ### csbu_top_properties.sv
// port assertions for the compare, skip and branch unit
`timescale 1ns/100ps
module csbu_top_properties
  import csbu_pkg::*;
#(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7
) (
  input wire logic               clk_i,
  input wire logic               sys_rst_i,
  input wire logic               op_valid_i,
  input wire csbu_pkg::csbu_op_t op_i,
  input wire logic [7:0]         rd_val_i,
  input wire logic [7:0]         rr_val_i,
  input wire logic [OFS_W-1:0]   offset_i,
  input wire logic [PC_W-1:0]    pc_i,
  input wire logic               next_two_word_i,
  input wire logic [7:0]         status_register_i,
  input wire logic               op_ready_o,
  input wire logic               done_o,
  input wire logic               pc_load_o,
  input wire logic [PC_W-1:0]    pc_target_o,
  input wire logic               status_register_we_o,
  input wire logic [1:0]         cycles_o
);
  import csbu_pkg::*;
  logic            acc;
  logic            cmp;
  logic            zf;
  logic [PC_W-1:0] tgt;
  logic [PC_W-1:0] skp;
  assign acc = op_valid_i && op_ready_o;
  assign cmp = op_i inside {op_compare_regs, op_compare_regs_with_carry,
                            op_compare_immediate};
  assign zf  = status_register_i[1];
  assign tgt = pc_i + PC_W'(signed'(offset_i)) + 1'h1;
  assign skp = pc_i + (next_two_word_i ? 2'h3 : 2'h2);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_done_after_accept: assert property (acc |=> done_o)
    else $error("no done after accept");
  a_taken_one_stall: assert property (done_o && cycles_o == 2'h2 |->
    !op_ready_o ##1 op_ready_o) else $error("taken stall wrong");
  a_skip_two_stalls: assert property (done_o && cycles_o == 2'h3 |->
    !op_ready_o [*2] ##1 op_ready_o) else $error("two word stall wrong");
  a_load_vs_cycles: assert property (done_o |->
    pc_load_o == (cycles_o != 2'h1)) else $error("load and cycles differ");
  a_branch_target: assert property (acc && op_i >= op_branch_status_bit_set
    |=> pc_target_o == $past(tgt)) else $error("branch target wrong");
  a_flags_kept: assert property (acc && !cmp |=> !status_register_we_o)
    else $error("flags written by non compare");
  a_compare_flags: assert property (acc && cmp |=> status_register_we_o &&
    !pc_load_o && cycles_o == 2'h1) else $error("compare result wrong");
  a_equal_skip: assert property (acc && op_i == op_compare_skip_equal &&
    rd_val_i == rr_val_i |=> pc_load_o && pc_target_o == $past(skp))
    else $error("equal skip wrong");
  a_equal_branch: assert property (acc && op_i == op_branch_equal &&
    !status_register_we_o |=> pc_load_o == $past(zf)) else $error("equal branch wrong");
  c_taken: cover property (done_o && pc_load_o && cycles_o == 2'h2);
  c_two_word: cover property (done_o && cycles_o == 2'h3);
  c_compare: cover property (status_register_we_o);
endmodule

bind csbu_top csbu_top_properties #(.PC_W(PC_W), .OFS_W(OFS_W)) i_props (
  .clk_i, .sys_rst_i, .op_valid_i, .op_i, .rd_val_i, .rr_val_i, .offset_i,
  .pc_i, .next_two_word_i, .status_register_i, .op_ready_o, .done_o, .pc_load_o,
  .pc_target_o, .status_register_we_o, .cycles_o);

// ### csbu_core_model.sv
// fetch side of the core: counts program counter redirections
`timescale 1ns/100ps
module csbu_core_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        done_i,
  input  wire logic        pc_load_i,
  output logic      [15:0] loads_o
);
  // a load without done would redirect fetch twice, so gate on both
  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      loads_o <= 16'h0;
    else if (done_i && pc_load_i)
      loads_o <= loads_o + 16'h1;
  end
endmodule

// ### csbu_top_tb.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/100ps
module csbu_top_tb;
  import csbu_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, op_valid_i = 0, next_two_word_i = 0;
  logic        pready_o, pslverr_o, op_ready_o, done_o, pc_load_o;
  logic        status_register_we_o, perr, last_cmp = 0;
  logic [7:0]  paddr_i = 0, rd_val_i = 0, rr_val_i = 0, io_val_i = 0;
  logic [7:0]  status_register_i = 0, status_register_o, sr = 0;
  logic [2:0]  bit_sel_i = 0;
  logic [6:0]  offset_i = 0;
  logic [15:0] pc_i = 0, pc_target_o, loads, tk = 0, nx = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rdat, stat;
  logic [1:0]  cycles_o;
  logic [28:0] e;
  csbu_op_t    op_i = op_compare_regs;
  logic [28:0] exp_q[$];
  int          err_total = 0, samples_checked = 0, seed = 95306;
  int          fb[9] = '{1, 0, 0, 2, 2, 5, 6, 3, 7};

  csbu_top i_dut (.clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i,
    .pwrite_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .op_valid_i,
    .op_i, .rd_val_i, .rr_val_i, .io_val_i, .bit_sel_i, .offset_i, .pc_i,
    .next_two_word_i, .status_register_i, .op_ready_o, .done_o, .pc_load_o,
    .pc_target_o, .status_register_we_o, .status_register_o, .cycles_o);
  csbu_core_model i_core (.clk_i, .sys_rst_i, .done_i(done_o),
    .pc_load_i(pc_load_o), .loads_o(loads));

  always #10 clk_i = ~clk_i;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'h1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    // request stands until the edge at which pready is seen high
    do @(posedge clk_i); while (pready_o !== 1'h1);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  // caller stands just after a rising edge; op_valid_i stays up between ops
  task automatic run(input csbu_op_t o, input logic [7:0] a, b, io,
                     input logic [2:0] s, input logic [6:0] k, input logic tw);
    logic [15:0] pc, t;
    logic [8:0]  r;
    logic [4:0]  hh;
    logic [7:0]  ns;
    logic [1:0]  cy;
    logic        ci, f, hit, br, cmp;
    pc = 16'($random(seed));
    cmp = o inside {op_compare_regs, op_compare_regs_with_carry,
                    op_compare_immediate};
    br = o >= op_branch_status_bit_set;
    ci = (o == op_compare_regs_with_carry) & sr[0];
    r = {1'h0, a} - b - ci;
    hh = {1'h0, a[3:0]} - b[3:0] - ci;
    ns = sr;
    ns[0] = r[8];
    ns[1] = r[7:0] == 8'h0;
    ns[2] = r[7];
    ns[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    ns[5] = hh[4];
    f = br ? sr[fb[(o - 10) / 2]] : 1'h0;
    if (o <= op_branch_status_bit_clear)
      f = sr[s];
    if (o inside {op_branch_signed_ge, op_branch_signed_lt})
      f = sr[2] ^ sr[3];
    hit = (o == op_compare_skip_equal) && a == b;
    if (o inside {op_skip_reg_bit_clear, op_skip_reg_bit_set})
      hit = b[s] ^ !o[0];
    if (o inside {op_skip_io_bit_clear, op_skip_io_bit_set})
      hit = io[s] ^ !o[0];
    if (br)
      hit = f ^ o[0] ^ (o inside {op_branch_same_or_higher, op_branch_lower,
                                  op_branch_signed_ge, op_branch_signed_lt});
    t = br ? pc + 16'(signed'(k)) + 16'h1 : pc + (tw ? 16'h3 : 16'h2);
    cy = !hit ? 2'h1 : (br || !tw) ? 2'h2 : 2'h3;
    op_valid_i <= 1'h1;
    op_i <= o;
    rd_val_i <= a;
    rr_val_i <= b;
    io_val_i <= io;
    bit_sel_i <= s;
    offset_i <= k;
    pc_i <= pc;
    next_two_word_i <= tw;
    status_register_i <= sr;
    do @(negedge clk_i); while (op_ready_o !== 1'h1);
    @(posedge clk_i);
    exp_q.push_back({cmp, hit, cmp ? 16'h0 : t, cy, cmp, cmp ? ns : 8'h0});
    stat = {27'h0, cmp, 1'h0, hit, cy};
    if (cmp)
      sr = ns;
    last_cmp = cmp;
    nx++;
    tk += 16'(hit);
  endtask

  always @(negedge clk_i) begin
    if (!sys_rst_i && done_o === 1'h1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      check({pc_load_o, e[28] ? 16'h0 : pc_target_o, cycles_o, status_register_we_o,
             status_register_we_o ? status_register_o : 8'h0}, 32'(e[27:0]));
    end
  end

  // 303 ops of at most three cycles each, plus a few register accesses
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    apb(8'h00, 1'h1, 32'h0);
    @(negedge clk_i);
    check(32'(op_ready_o), 32'h0);
    apb(8'h00, 1'h1, 32'h3);
    run(op_compare_regs, 8'h5a, 8'h5a, 8'h0, 3'h0, 7'h0, 1'h0);
    run(op_branch_equal, 8'h0, 8'h0, 8'h0, 3'h0, 7'h7f, 1'h0);
    run(op_compare_skip_equal, 8'h11, 8'h11, 8'h0, 3'h0, 7'h0, 1'h1);
    repeat (300) begin
      if (!last_cmp)
        sr = 8'($random(seed));
      run(csbu_op_t'(5'($unsigned($random(seed)) % 28)), 8'($random(seed)),
          8'($random(seed)), 8'($random(seed)), 3'($random(seed)),
          7'($random(seed)), 1'($random(seed)));
    end
    op_valid_i <= 1'h0;
    // core register catches up with the last compare's flags
    status_register_i <= sr;
    repeat (4) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
    check({16'h0, loads}, {16'h0, tk});
    apb(8'h08, 1'h0, 32'h0);
    check(rdat, {nx, tk});
    apb(8'h04, 1'h0, 32'h0);
    check(rdat, stat);
    apb(8'h0c, 1'h0, 32'h0);
    check(rdat, {24'h0, sr});
    apb(8'h10, 1'h0, 32'h0);
    check({31'h0, perr}, 32'h1);
    end_of_test;
  end
endmodule
